// [core/dfp_pkg.sv]
package dfp_pkg;

	// parameter numbers of the bank, as the master addresses them
	localparam logic [15:0] DFP_OFS_FAULT = 16'h0081;
	localparam logic [15:0] DFP_OFS_P1_RISE = 16'h0082;
	localparam logic [15:0] DFP_OFS_P1_FALL = 16'h0083;
	localparam logic [15:0] DFP_OFS_P2_RISE = 16'h0084;
	localparam logic [15:0] DFP_OFS_P2_FALL = 16'h0085;
	localparam logic [15:0] DFP_OFS_CTRL_COPY = 16'h0086;
	localparam logic [15:0] DFP_OFS_STAT_COPY = 16'h0087;
	localparam logic [15:0] DFP_OFS_ACCEL = 16'h0088;
	localparam logic [15:0] DFP_OFS_DECEL = 16'h0089;

	// fault latch layout: bits 1..7 and 9..11 used, the rest reserved
	localparam logic [15:0] DFP_FAULT_VALID = 16'h0EFE;
	// faults whose clearing forces a cold start: bits 1,3,5,6,7
	localparam logic [15:0] DFP_FAULT_COLD = 16'h00EA;
	localparam logic [15:0] DFP_FAULT_RST = 16'h0000;

	// flag positions in the telegram and diagnostic words
	localparam int DFP_STAT_FAULT_BIT = 13;
	localparam int DFP_DIAG_FAULT_BIT = 15;
	localparam int DFP_CTRL_QSTOP_BIT = 15;

	// probe control bit positions
	localparam int DFP_PC_P1_RISE = 0;
	localparam int DFP_PC_P1_FALL = 1;
	localparam int DFP_PC_P2_RISE = 2;
	localparam int DFP_PC_P2_FALL = 3;

	// ramp limits in milliseconds
	localparam logic signed [31:0] DFP_ACCEL_MIN = 32'sh00000001;
	localparam logic signed [31:0] DFP_ACCEL_MAX = 32'sh00007FFF;
	localparam logic signed [31:0] DFP_ACCEL_DEF = 32'sh0000000A;
	localparam logic signed [31:0] DFP_DECEL_MIN = -32'sh00007FFF;
	localparam logic signed [31:0] DFP_DECEL_MAX = -32'sh00000001;
	localparam logic signed [31:0] DFP_DECEL_DEF = -32'sh0000000A;

	// communication phases in which ramp limits may be written
	localparam logic [2:0] DFP_PHASE_WR_LO = 3'h2;
	localparam logic [2:0] DFP_PHASE_WR_HI = 3'h4;

	// timing: one millisecond at the 10 ns control clock
	localparam int DFP_CLK_NS = 10;
	localparam int DFP_MS_NS = 1000000;
	localparam int DFP_MS_CYCLES = DFP_MS_NS / DFP_CLK_NS;
	localparam int DFP_VEL_W = 32;

	// parameter port request and answer
	typedef struct packed {
		logic [15:0] sel;
		logic rd;
		logic wr;
		logic [31:0] wdata;
	} dfp_param_req_t;

	typedef struct packed {
		logic [31:0] rdata;
		logic ack;
		logic err;
	} dfp_param_rsp_t;

	// the four probe captures, offered to the cyclic telegram
	typedef struct packed {
		logic [31:0] p1_rise;
		logic [31:0] p1_fall;
		logic [31:0] p2_rise;
		logic [31:0] p2_fall;
	} dfp_probe_set_t;

	// fault reaction of the axis
	typedef enum logic [1:0] {
		DFP_RUN,
		DFP_STOP,
		DFP_OFF
	} dfp_react_t;

endpackage : dfp_pkg

// [core/dfp_probe.sv]
`timescale 1ns/1ps
// one probe input with its rising and falling capture registers
module dfp_probe
	import dfp_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic probe_pin_in,
	input wire logic rise_en_in,
	input wire logic fall_en_in,
	input wire logic [31:0] pos_in,
	output logic [31:0] rise_pos_out,
	output logic [31:0] fall_pos_out
);

	typedef struct packed {
		logic s1;          // first synchroniser stage, read by s2 only
		logic s2;          // synchronised level
		logic s3;          // previous synchronised level
		logic [31:0] rise; // rising-edge capture
		logic [31:0] fall; // falling-edge capture
	} dfp_probe_st_t;

	dfp_probe_st_t st_q;
	dfp_probe_st_t st_d;
	logic edge_rise;
	logic edge_fall;

	// edges only from settled stages, never from s1
	assign edge_rise = st_q.s2 & ~st_q.s3;
	assign edge_fall = ~st_q.s2 & st_q.s3;

	// next state: sync chain and gated captures
	always_comb begin
		// captures hold unless an edge qualifies
		st_d = st_q;
		st_d.s1 = probe_pin_in;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		if (rise_en_in && edge_rise) begin
			st_d.rise = pos_in;
		end
		if (fall_en_in && edge_fall) begin
			st_d.fall = pos_in;
		end
	end

	// state register; capture values reset to zero
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rise_pos_out = st_q.rise;
	assign fall_pos_out = st_q.fall;

	a_probe_rise_cap: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(rise_en_in && edge_rise) |=> (rise_pos_out == $past(pos_in)))
		else $error("probe rise capture missed");

	a_probe_keeps: assert property (
		@(posedge clk_in) disable iff (rst_in)
		!(rise_en_in && edge_rise) && !(fall_en_in && edge_fall)
		|=> $stable(rise_pos_out) && $stable(fall_pos_out))
		else $error("probe capture changed without edge");

endmodule : dfp_probe

// [core/dfp_ramp.sv]
`timescale 1ns/1ps
// velocity ramp, stepping once per millisecond tick
module dfp_ramp
	import dfp_pkg::*;
#(
	parameter int VW = DFP_VEL_W
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic tick_in,
	input wire logic signed [VW-1:0] target_in,
	input wire logic [VW-1:0] vmax_in,
	input wire logic [15:0] accel_ms_in,
	input wire logic [15:0] decel_ms_in,
	output logic signed [VW-1:0] vel_out,
	output logic stand_out
);

	typedef struct packed {
		logic signed [VW-1:0] vel; // limited velocity
	} dfp_ramp_st_t;

	dfp_ramp_st_t st_q;
	dfp_ramp_st_t st_d;

	// velocity change per tick for a full swing in ms ticks
	function automatic logic [VW-1:0] step_of(input logic [VW-1:0] vmax,
			input logic [15:0] ms);
		logic [VW-1:0] q;
		q = vmax / VW'((ms == 16'h0000) ? 16'h0001 : ms);
		// never zero, else a small vmax would freeze the ramp
		return (q == '0) ? VW'(1) : q;
	endfunction : step_of

	// next velocity: accel step away from zero, decel step toward it
	always_comb begin
		logic away;
		logic [VW-1:0] step;
		logic signed [VW:0] diff;
		away = 1'b0;
		step = '0;
		diff = '0;
		st_d = st_q;
		away = (target_in > st_q.vel && st_q.vel >= 0) ||
			(target_in < st_q.vel && st_q.vel <= 0);
		step = away ? step_of(vmax_in, accel_ms_in) :
			step_of(vmax_in, decel_ms_in);
		diff = (VW+1)'(target_in) - (VW+1)'(st_q.vel);
		if (tick_in) begin
			if (diff > $signed({1'b0, step})) begin
				st_d.vel = st_q.vel + $signed(step);
			end else if (diff < -$signed({1'b0, step})) begin
				st_d.vel = st_q.vel - $signed(step);
			end else begin
				st_d.vel = target_in;
			end
		end
	end

	// state register; axis starts at standstill
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign vel_out = st_q.vel;
	assign stand_out = (st_q.vel == '0);

	a_ramp_tick_only: assert property (
		@(posedge clk_in) disable iff (rst_in)
		!tick_in |=> $stable(vel_out))
		else $error("velocity moved between ticks");

endmodule : dfp_ramp

// [core/dfp_bank.sv]
`timescale 1ns/1ps
module dfp_bank
	import dfp_pkg::*;
#(
	// one millisecond of control clock, shortened in simulation
	parameter int MS_CYCLES = DFP_MS_CYCLES
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire dfp_param_req_t PARAM_REQ_IN,
	output dfp_param_rsp_t PARAM_RSP_OUT,
	input wire logic [2:0] PHASE_IN,
	input wire logic [15:0] FAULT_SRC_IN,
	input wire logic FAULT_RESET_IN,
	output logic COLD_START_OUT,
	input wire logic [15:0] CTRL_WORD_IN,
	input wire logic CTRL_VALID_IN,
	input wire logic [15:0] STATUS_BASE_IN,
	input wire logic STATUS_SEND_IN,
	output logic [15:0] STATUS_WORD_OUT,
	output logic [15:0] DIAG_WORD_OUT,
	input wire logic [3:0] PROBE_CTRL_IN,
	input wire logic PROBE1_PIN_IN,
	input wire logic PROBE2_PIN_IN,
	input wire logic [31:0] MOTOR_POS_IN,
	input wire logic [31:0] EXT_POS_IN,
	output dfp_probe_set_t PROBE_POS_OUT,
	input wire logic POS_LIMIT_IN,
	input wire logic [15:0] QUICK_DECEL_MS_IN,
	input wire logic signed [31:0] VEL_CMD_IN,
	input wire logic [31:0] VMAX_IN,
	output logic signed [31:0] VEL_OUT,
	output logic POWER_EN_OUT
);

	// whole state of the bank in one record
	typedef struct packed {
		dfp_react_t react;        // fault reaction state
		logic [15:0] fault;       // latched vendor faults
		logic [16:0] ms_cnt;      // millisecond prescaler
		logic ms_tick;            // one-cycle tick per millisecond
		logic cold;               // cold start request pulse
		logic [15:0] ctrl_copy;   // last master control word
		logic [15:0] stat_word;   // status word being sent
		logic [15:0] stat_copy;   // last status word sent
		logic signed [31:0] accel; // accel limit, ms
		logic signed [31:0] decel; // decel limit, ms, negative
		logic [31:0] rdata;       // parameter read data
		logic ack;                // parameter answer strobe
		logic err;                // parameter refused
	} dfp_top_st_t;

	localparam dfp_top_st_t ST_RST = '{
		react: DFP_RUN,
		fault: DFP_FAULT_RST,
		ms_cnt: '0,
		ms_tick: 1'b0,
		cold: 1'b0,
		ctrl_copy: '0,
		stat_word: '0,
		stat_copy: '0,
		accel: DFP_ACCEL_DEF,
		decel: DFP_DECEL_DEF,
		rdata: '0,
		ack: 1'b0,
		err: 1'b0
	};

	dfp_top_st_t st_q;
	dfp_top_st_t st_d;

	logic fault_any;        // any latched fault
	logic quick_sel;        // quick decel limit in force
	logic stand;            // ramp output at standstill
	logic [15:0] fault_new; // fault causes seen this cycle
	logic [15:0] decel_mag; // decel time handed to the ramp
	logic signed [31:0] vel_target;
	logic wr_phase_ok;      // writes allowed in this phase
	dfp_probe_set_t probes;

	// only the documented fault bits are latched
	// bits 9..11 included, none in the cold set
	// reserved bits 0, 8, 12..15 never set
	assign fault_new = FAULT_SRC_IN & DFP_FAULT_VALID;
	assign fault_any = (st_q.fault != DFP_FAULT_RST);

	// quick limit on position limit, fault or disable
	assign quick_sel = POS_LIMIT_IN || fault_any ||
		st_q.ctrl_copy[DFP_CTRL_QSTOP_BIT];
	assign decel_mag = quick_sel ? QUICK_DECEL_MS_IN :
		16'(-st_q.decel);

	// command zero velocity once a fault is latched
	assign vel_target = (st_q.react == DFP_RUN) ? VEL_CMD_IN : '0;

	// writes are honoured only in phases two to four
	assign wr_phase_ok = (PHASE_IN >= DFP_PHASE_WR_LO) &&
		(PHASE_IN <= DFP_PHASE_WR_HI);

	// next state of the bank
	always_comb begin
		logic signed [31:0] wval;
		wval = '0;
		st_d = st_q;
		wval = $signed(PARAM_REQ_IN.wdata);

		// millisecond prescaler feeding the ramp
		st_d.ms_tick = 1'b0;
		if (st_q.ms_cnt == 17'(MS_CYCLES - 1)) begin
			st_d.ms_cnt = '0;
			st_d.ms_tick = 1'b1;
		end else begin
			st_d.ms_cnt = st_q.ms_cnt + 17'h00001;
		end

		// clear only on the reset procedure
		st_d.cold = 1'b0;
		if (FAULT_RESET_IN) begin
			// cold start if a latched fault needs it
			st_d.cold = ((st_q.fault & DFP_FAULT_COLD) != '0);
			st_d.fault = DFP_FAULT_RST;
		end
		// a live cause sets its bit, winning over clear
		st_d.fault = st_d.fault | fault_new;

		// fault reaction: stop, then drop the power stage
		case (st_q.react)
			DFP_RUN: begin
				// any latched fault starts the stop
				if (fault_any) begin
					st_d.react = DFP_STOP;
				end
			end
			DFP_STOP: begin
				// power stays on until the ramp reaches zero
				if (stand) begin
					st_d.react = DFP_OFF;
				end
			end
			DFP_OFF: begin
				// back to service once the latch is cleared
				if (!fault_any) begin
					st_d.react = DFP_RUN;
				end
			end
			default: begin
				st_d.react = DFP_OFF;
			end
		endcase

		if (CTRL_VALID_IN) begin
			st_d.ctrl_copy = CTRL_WORD_IN;
		end

		// class-one flag rides in the status word
		st_d.stat_word = STATUS_BASE_IN;
		st_d.stat_word[DFP_STAT_FAULT_BIT] = fault_any;

		// mirror each status word put on the telegram
		if (STATUS_SEND_IN) begin
			st_d.stat_copy = st_q.stat_word;
		end

		// parameter port: answer one cycle after the request
		st_d.ack = PARAM_REQ_IN.rd || PARAM_REQ_IN.wr;
		st_d.err = 1'b0;
		st_d.rdata = '0;
		if (PARAM_REQ_IN.rd) begin
			// reads of the bank, narrow data in low bits
			case (PARAM_REQ_IN.sel)
				DFP_OFS_FAULT: st_d.rdata = {16'h0000, st_q.fault};
				DFP_OFS_P1_RISE: st_d.rdata = probes.p1_rise;
				DFP_OFS_P1_FALL: st_d.rdata = probes.p1_fall;
				DFP_OFS_P2_RISE: st_d.rdata = probes.p2_rise;
				DFP_OFS_P2_FALL: st_d.rdata = probes.p2_fall;
				DFP_OFS_CTRL_COPY: begin
					st_d.rdata = {16'h0000, st_q.ctrl_copy};
				end
				DFP_OFS_STAT_COPY: begin
					st_d.rdata = {16'h0000, st_q.stat_copy};
				end
				DFP_OFS_ACCEL: st_d.rdata = st_q.accel;
				DFP_OFS_DECEL: st_d.rdata = st_q.decel;
				// unknown parameter number
				default: st_d.err = 1'b1;
			endcase
		end else if (PARAM_REQ_IN.wr) begin
			// only the ramp limits are writable; all else refused
			case (PARAM_REQ_IN.sel)
				DFP_OFS_ACCEL: begin
					if (wr_phase_ok && wval >= DFP_ACCEL_MIN &&
							wval <= DFP_ACCEL_MAX) begin
						st_d.accel = wval;
					end else begin
						st_d.err = 1'b1;
					end
				end
				DFP_OFS_DECEL: begin
					if (wr_phase_ok && wval >= DFP_DECEL_MIN &&
							wval <= DFP_DECEL_MAX) begin
						st_d.decel = wval;
					end else begin
						st_d.err = 1'b1;
					end
				end
				// read-only or unknown parameter
				default: st_d.err = 1'b1;
			endcase
		end
	end

	// state register
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// falling edge enabled by its own bit
	dfp_probe u_probe_one (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.probe_pin_in(PROBE1_PIN_IN),
		.rise_en_in(PROBE_CTRL_IN[DFP_PC_P1_RISE]),
		.fall_en_in(PROBE_CTRL_IN[DFP_PC_P1_FALL]),
		.pos_in(MOTOR_POS_IN),
		.rise_pos_out(probes.p1_rise),
		.fall_pos_out(probes.p1_fall)
	);

	// falling edge enabled by its own bit
	dfp_probe u_probe_two (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.probe_pin_in(PROBE2_PIN_IN),
		.rise_en_in(PROBE_CTRL_IN[DFP_PC_P2_RISE]),
		.fall_en_in(PROBE_CTRL_IN[DFP_PC_P2_FALL]),
		.pos_in(EXT_POS_IN),
		.rise_pos_out(probes.p2_rise),
		.fall_pos_out(probes.p2_fall)
	);

	// ramp uses the accel limit and the chosen decel limit
	dfp_ramp #(
		.VW(DFP_VEL_W)
	) u_ramp (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.tick_in(st_q.ms_tick),
		.target_in(vel_target),
		.vmax_in(VMAX_IN),
		.accel_ms_in(st_q.accel[15:0]),
		.decel_ms_in(decel_mag),
		.vel_out(VEL_OUT),
		.stand_out(stand)
	);

	// captures go straight to the cyclic telegram
	assign PROBE_POS_OUT = probes;

	// outputs from the state record
	assign PARAM_RSP_OUT = '{rdata: st_q.rdata, ack: st_q.ack,
		err: st_q.err};
	assign COLD_START_OUT = st_q.cold;
	assign STATUS_WORD_OUT = st_q.stat_word;
	// class-one diagnostic carries the fault flag
	assign DIAG_WORD_OUT = {fault_any, 15'h0000};
	// power stage off only after the stop has finished
	assign POWER_EN_OUT = (st_q.react != DFP_OFF);

	// fault noticed while running
	sequence s_fault_in_run;
		(st_q.react == DFP_RUN) && fault_any;
	endsequence

	// stop phase ending at standstill
	sequence s_stop_done;
		(st_q.react == DFP_STOP) && stand;
	endsequence

	a_fault_to_stop: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		s_fault_in_run |=> (st_q.react == DFP_STOP) && POWER_EN_OUT)
		else $error("fault did not start the stop");

	a_stop_then_off: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		s_stop_done |=> !POWER_EN_OUT)
		else $error("power stage not disabled at standstill");

	a_off_needs_stand: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		$fell(POWER_EN_OUT) |-> $past(stand))
		else $error("power dropped while axis moving");

	a_fault_latches: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		(fault_new != '0) |=>
		((st_q.fault & $past(fault_new)) == $past(fault_new)) ##1
		STATUS_WORD_OUT[DFP_STAT_FAULT_BIT])
		else $error("fault bit or status flag not set");

	a_fault_hold: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		((st_q.fault & ~st_d.fault) != '0) |-> FAULT_RESET_IN)
		else $error("fault bit cleared without reset procedure");

	a_cold_start: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		FAULT_RESET_IN && ((st_q.fault & DFP_FAULT_COLD) != '0)
		|=> COLD_START_OUT ##1 !COLD_START_OUT)
		else $error("cold start pulse wrong");

	a_reserved_zero: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		(st_q.fault & ~DFP_FAULT_VALID) == '0)
		else $error("reserved fault bit set");

	a_ctrl_copy: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		CTRL_VALID_IN |=> (st_q.ctrl_copy == $past(CTRL_WORD_IN)))
		else $error("control word not mirrored");

	a_status_copy: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		STATUS_SEND_IN |=> (st_q.stat_copy == $past(STATUS_WORD_OUT)))
		else $error("status word not mirrored");

	a_limit_ranges: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		(st_q.decel <= DFP_DECEL_MAX) && (st_q.decel >= DFP_DECEL_MIN) &&
		(st_q.accel >= DFP_ACCEL_MIN) && (st_q.accel <= DFP_ACCEL_MAX))
		else $error("ramp limit out of range");

	a_quick_decel: assert property (
		@(posedge CLK_IN) disable iff (RST_IN)
		(POS_LIMIT_IN || fault_any || st_q.ctrl_copy[DFP_CTRL_QSTOP_BIT])
		|-> (decel_mag == QUICK_DECEL_MS_IN))
		else $error("quick decel limit not selected");

endmodule : dfp_bank

// [tb/dfp_master.sv]
`timescale 1ns/1ps
// cyclic fieldbus master: one control word frame and one status frame
module dfp_master
	import dfp_pkg::*;
#(
	parameter int CYC = 8
) (
	input wire logic clk_in,
	input wire logic [15:0] word_in,
	output logic [15:0] ctrl_out,
	output logic valid_out,
	output logic send_out
);
	int n = 0; // cycle within the telegram period
	// quiet lines until the first telegram slot
	initial begin
		ctrl_out = 16'h0000;
		valid_out = 1'b0;
		send_out = 1'b0;
	end
	// telegram slots; between frames the word shows its inverse, not a copy
	// disable request travels as control word bit 15
	always @(posedge clk_in) begin
		n <= (n + 1) % CYC;
		valid_out <= #1 (n == 0);
		send_out <= #1 (n == 1);
		ctrl_out <= #1 (n == 0) ? word_in : ~word_in;
	end
endmodule : dfp_master

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
	import dfp_pkg::*;
	localparam int MS = 4; // shortened millisecond keeps ramps short
	logic CLK_IN = 1'b0;
	logic RST_IN = 1'b1;
	dfp_param_req_t req = '0;
	dfp_param_rsp_t rsp;
	logic [2:0] phase = 3'h3;
	logic [15:0] fsrc = 16'h0000, cword = 16'h0000, cw, stat, diag, fx;
	logic frst = 1'b0, p1 = 1'b0, p2 = 1'b0, plim = 1'b0;
	logic cold, pen, cv, ss, e;
	logic [3:0] pctl = 4'h0;
	logic [31:0] mpos = 32'h0, epos = 32'h0, d;
	logic signed [31:0] vcmd = 32'sh0, vel, v1;
	dfp_probe_set_t pset, pexp = '0;
	int error_cnt = 0;
	int samples_checked = 0;
	// write table: target, value, phase, refusal expected
	logic [15:0] sl[13] = '{DFP_OFS_ACCEL, DFP_OFS_ACCEL, DFP_OFS_ACCEL,
		DFP_OFS_ACCEL, DFP_OFS_ACCEL, DFP_OFS_ACCEL, DFP_OFS_DECEL,
		DFP_OFS_DECEL, DFP_OFS_DECEL, DFP_OFS_DECEL, DFP_OFS_DECEL,
		DFP_OFS_FAULT, DFP_OFS_P1_RISE};
	logic [31:0] wv[13] = '{32'h7FFF, 32'h1, 32'hA, 32'h0, 32'h8000, 32'h5,
		32'hFFFF8001, 32'hFFFFFFEC, 32'h0, 32'hFFFF8000, 32'hFFFFFFFB,
		32'h1, 32'h1};
	logic [2:0] ph[13] = '{3'h2, 3'h4, 3'h3, 3'h3, 3'h3, 3'h1, 3'h3, 3'h3,
		3'h3, 3'h3, 3'h5, 3'h3, 3'h3};
	logic we[13] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0,
		1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
	always #5 CLK_IN = ~CLK_IN;
	dfp_bank #(.MS_CYCLES(MS)) i_dfp_bank (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
		.PARAM_REQ_IN(req), .PARAM_RSP_OUT(rsp), .PHASE_IN(phase),
		.FAULT_SRC_IN(fsrc), .FAULT_RESET_IN(frst), .COLD_START_OUT(cold),
		.CTRL_WORD_IN(cw), .CTRL_VALID_IN(cv), .STATUS_BASE_IN(16'hA5C3),
		.STATUS_SEND_IN(ss), .STATUS_WORD_OUT(stat), .DIAG_WORD_OUT(diag),
		.PROBE_CTRL_IN(pctl), .PROBE1_PIN_IN(p1), .PROBE2_PIN_IN(p2),
		.MOTOR_POS_IN(mpos), .EXT_POS_IN(epos), .PROBE_POS_OUT(pset),
		.POS_LIMIT_IN(plim), .QUICK_DECEL_MS_IN(16'h2),
		.VEL_CMD_IN(vcmd), .VMAX_IN(32'h3E8), .VEL_OUT(vel),
		.POWER_EN_OUT(pen));
	dfp_master #(.CYC(8)) i_dfp_master (.clk_in(CLK_IN), .word_in(cword),
		.ctrl_out(cw), .valid_out(cv), .send_out(ss));
	// one place decides the outcome of the run
	task automatic print_verdict();
		if (error_cnt == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	// compare with four-state equality so unknowns never match
	task automatic chk(input string nm, input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// inputs move just after the edge, always by the same 1 ns
	task automatic tick(input int n);
		repeat (n) @(posedge CLK_IN);
		#1;
	endtask : tick
	// one-clock request, answer caught in a bounded window
	task automatic acc(input logic [15:0] s, input logic w, input [31:0] wd);
		int i;
		req.sel = s;
		req.rd = !w;
		req.wr = w;
		req.wdata = wd;
		tick(1);
		req.rd = 1'b0;
		req.wr = 1'b0;
		for (i = 0; i < 4 && rsp.ack !== 1'b1; i++) tick(1);
		if (rsp.ack !== 1'b1) begin
			error_cnt++;
			print_verdict();
		end
		d = rsp.rdata;
		e = rsp.err;
		// an idle clock so a strobe is never lowered and raised at once
		tick(1);
	endtask : acc
	task automatic rd(input logic [15:0] s, input [31:0] x, input string nm);
		acc(s, 1'b0, 32'h0);
		chk(nm, d, x);
		chk("read err", e, 1'b0);
	endtask : rd
	// velocity change over whole ticks after a settling wait
	task automatic slope(input logic signed [31:0] t, input int pre, n,
		input logic [31:0] dv, input string nm);
		vcmd = t;
		tick(pre * MS);
		v1 = vel;
		tick(n * MS);
		chk(nm, vel - v1, dv);
	endtask : slope
	// hang guard well beyond the cycles the run needs
	initial begin
		#200000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		int k;
		int j;
		int i;
		tick(6);
		RST_IN = 1'b0;
		tick(1);
		rd(DFP_OFS_FAULT, 32'h0, "fault reset");
		rd(DFP_OFS_ACCEL, DFP_ACCEL_DEF, "accel def");
		rd(DFP_OFS_DECEL, DFP_DECEL_DEF, "decel def");
		// range and phase window of writes
		for (k = 0; k < 13; k++) begin
			phase = ph[k];
			acc(sl[k], 1'b1, wv[k]);
			chk("write err", e, we[k]);
		end
		phase = 3'h3;
		rd(DFP_OFS_ACCEL, 32'hA, "accel kept");
		rd(DFP_OFS_DECEL, 32'hFFFFFFEC, "decel kept");
		acc(16'h0090, 1'b0, 32'h0);
		chk("unmapped", e, 1'b1);
		for (k = 0; k < 16; k++) begin
			fx = (16'h1 << k) & 16'h0EFE;
			fsrc = 16'h1 << k;
			tick(2);
			fsrc = 16'h0;
			tick(1);
			rd(DFP_OFS_FAULT, fx, "latch");
			chk("status flag", stat[13], fx != 0);
			chk("diag flag", diag[15], fx != 0);
			for (i = 0; i < 40 && pen === 1'b1 && fx != 0; i++) tick(1);
			chk("power", pen, fx == 0);
			frst = 1'b1;
			tick(1);
			frst = 1'b0;
			chk("cold", cold, (fx & 16'h00EA) != 0);
			tick(2);
			rd(DFP_OFS_FAULT, 32'h0, "cleared");
			chk("power back", pen, 1'b1);
		end
		// one edge kind enabled per pass
		for (k = 0; k < 4; k++) begin
			pctl = 4'h1 << k;
			mpos = 32'h10000000 + k;
			epos = 32'h20000000 + k;
			tick(1);
			p1 = 1'b1;
			p2 = 1'b1;
			tick(5);
			p1 = 1'b0;
			p2 = 1'b0;
			tick(5);
			case (k)
				0: pexp.p1_rise = mpos;
				1: pexp.p1_fall = mpos;
				2: pexp.p2_rise = epos;
				default: pexp.p2_fall = epos;
			endcase
			for (j = 0; j < 4; j++) begin
				rd(DFP_OFS_P1_RISE + 16'(j), pexp[127-32*j -: 32], "probe");
				chk("telegram", pset[127-32*j -: 32], pexp[127-32*j -: 32]);
			end
		end
		cword = 16'h3C5A;
		tick(20);
		rd(DFP_OFS_CTRL_COPY, 32'h3C5A, "ctrl copy");
		rd(DFP_OFS_STAT_COPY, 32'h85C3, "stat copy");
		// slopes: 100, 50 and 500 per tick
		slope(32'sh3E8, 2, 2, 32'h000000C8, "accel");
		tick(60);
		chk("top", vel, 32'h3E8);
		slope(32'sh0, 2, 2, 32'hFFFFFF9C, "decel");
		vcmd = 32'sh3E8;
		tick(100);
		plim = 1'b1;
		slope(32'sh0, 1, 1, 32'hFFFFFE0C, "quick lim");
		plim = 1'b0;
		vcmd = 32'sh3E8;
		cword = 16'h8000;
		tick(100);
		slope(32'sh0, 1, 1, 32'hFFFFFE0C, "quick req");
		// fault at speed: quick stop first, power off after
		cword = 16'h0000;
		vcmd = 32'sh3E8;
		tick(100);
		fsrc = 16'h0200;
		tick(1);
		fsrc = 16'h0;
		tick(2);
		chk("moving power", pen, 1'b1);
		// normal decel would need 80 cycles, quick decel fits in 40
		for (i = 0; i < 40 && pen === 1'b1; i++) tick(1);
		chk("stop vel", vel, 32'h0);
		chk("stopped power", pen, 1'b0);
		print_verdict();
	end
endmodule : tb
